/* hdl/ldtm_pkg.sv */
package ldtm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] LDTM_ENABLE_OFS = 8'h00;
  localparam logic [7:0] LDTM_REF_OFS = 8'h04;
  localparam logic [7:0] LDTM_AUX_OFS = 8'h08;
  localparam logic [7:0] LDTM_MAIN_OFS = 8'h0c;
  localparam logic [7:0] LDTM_STATUS_OFS = 8'h10;
  localparam logic [7:0] LDTM_IRQ_STATUS_OFS = 8'h14;
  localparam logic [7:0] LDTM_IRQ_MASK_OFS = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LDTM_EN_MAIN_BIT = 0;
  localparam int LDTM_EN_AUX_BIT = 1;
  localparam int LDTM_EN_TLOW_BIT = 2;
  localparam int LDTM_EN_THIGH_BIT = 3;
  localparam int LDTM_REF_SUB_LSB = 12;
  localparam int LDTM_AUX_PRESC_BIT = 12;
  localparam int LDTM_MAIN_SECOND_LSB = 12;
  localparam int LDTM_MAIN_THIRD_LSB = 20;
  localparam int LDTM_MAIN_PR_LSB = 24;
  localparam int LDTM_IRQ_GAINED_BIT = 0;
  localparam int LDTM_IRQ_LOST_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and ratio constants
  // ---------------------------------------------------------------
  localparam logic [3:0] LDTM_ENABLE_RST = 4'h0;
  localparam logic [1:0] LDTM_IRQ_RST = 2'h0;
  localparam logic [1:0] LDTM_PR_THREE_MOD = 2'h2;
  localparam logic [19:0] LDTM_MOD_LOW = 20'h00040;
  localparam logic [19:0] LDTM_MOD_MID = 20'h00041;
  localparam logic [19:0] LDTM_MOD_HIGH = 20'h00048;
  localparam logic [19:0] LDTM_AUX_PRESC_DIV = 20'h00004;

  typedef enum logic [1:0] {
    LDTM_SEL_LOCK,
    LDTM_SEL_REF,
    LDTM_SEL_AUX,
    LDTM_SEL_MAIN
  } ldtm_sel_type;

  typedef enum logic [1:0] {
    LDTM_PD_IDLE,
    LDTM_PD_WAIT_LOOP,
    LDTM_PD_WAIT_REF
  } ldtm_pd_state_type;

endpackage

/* hdl/ldtm_divider.sv */
`timescale 1ns/1ps
module ldtm_divider import ldtm_pkg::*; #(
  parameter int W = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic step,
  input wire logic [W-1:0] ratio,
  output logic tc_q
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic tc_d;

  // Ratio 0 or 1 passes every step
  always_comb begin
    count_d = count_q;
    tc_d = 1'b0;
    if (!enable) begin
      count_d = '0;
    end else if (step) begin
      if (ratio <= {{(W-1){1'b0}}, 1'b1} || count_q >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
        count_d = '0;
        tc_d = 1'b1;
      end else begin
        count_d = count_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      tc_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tc_q <= tc_d;
    end
  end

endmodule

/* hdl/ldtm_phase_lock.sv */
`timescale 1ns/1ps
module ldtm_phase_lock import ldtm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_edge,
  input wire logic ref_pulse,
  input wire logic loop_pulse,
  output logic locked_q
);

  ldtm_pd_state_type state_q;
  ldtm_pd_state_type state_d;
  logic locked_d;

  // Lock when the second pulse arrives before one more reference input edge
  always_comb begin
    state_d = state_q;
    locked_d = locked_q;
    unique case (state_q)
      LDTM_PD_IDLE: begin
        if (ref_pulse && loop_pulse) begin
          locked_d = 1'b1;
        end else if (ref_pulse) begin
          state_d = LDTM_PD_WAIT_LOOP;
        end else if (loop_pulse) begin
          state_d = LDTM_PD_WAIT_REF;
        end
      end
      LDTM_PD_WAIT_LOOP, LDTM_PD_WAIT_REF: begin
        if ((state_q == LDTM_PD_WAIT_LOOP) ? loop_pulse : ref_pulse) begin
          locked_d = 1'b1;
          state_d = LDTM_PD_IDLE;
        end else if (ref_edge || ref_pulse || loop_pulse) begin
          locked_d = 1'b0;
          state_d = LDTM_PD_IDLE;
        end
      end
      default: state_d = LDTM_PD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LDTM_PD_IDLE;
      locked_q <= 1'b0;
    end else begin
      state_q <= state_d;
      locked_q <= locked_d;
    end
  end

endmodule

/* hdl/ldtm_lock_detect_test_mux.sv */
`timescale 1ns/1ps
//
// Contract
// - With both select bits low, lock output is high only while the aux and the main detector each report lock or have their counter disabled.
// - A detector reports lock when its phase error is under one reference input cycle.
// - A loop whose counter enable is zero counts as locked whatever its phase.
// - The two test select bits of the enable word pick the lock output source.
// - Both select bits low, or no enable word written yet, gives the combined lock.
// - Select low bit alone routes the reference divider then sub-counter output.
// - In reference test the output rests low and pulses high at terminal count.
// - Select high bit alone makes the output rest high and pulse low at aux terminal count.
// - Both select bits high make the output rest high and pulse low at main terminal count.
// - The main divider counts the XOR of the test input and the prescaler output.
// - In two-modulus mode the main ratio is (first + 2) * 64 + second * 65.
//
module ldtm_lock_detect_test_mux import ldtm_pkg::*; #(
  parameter int REF_W = 12,
  parameter int AUX_W = 12,
  parameter int FIRST_W = 12,
  parameter int SECOND_W = 8,
  parameter int THIRD_W = 4,
  parameter int RATIO_W = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_input,
  input wire logic aux_input,
  input wire logic rf_input,
  input wire logic test_input,
  output logic lock_out,
  output logic irq
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic main_counter_enable_q, main_counter_enable_d;
  logic aux_counter_enable_q, aux_counter_enable_d;
  logic test_select_low_q, test_select_low_d;
  logic test_select_high_q, test_select_high_d;
  logic [REF_W-1:0] reference_ratio_divider_q, reference_ratio_divider_d;
  logic [2:0] reference_sub_counter_q, reference_sub_counter_d;
  logic [AUX_W-1:0] aux_ratio_divider_q, aux_ratio_divider_d;
  logic aux_prescale_select_q, aux_prescale_select_d;
  logic [FIRST_W-1:0] main_count_first_q, main_count_first_d;
  logic [SECOND_W-1:0] main_count_second_q, main_count_second_d;
  logic [THIRD_W-1:0] main_count_third_q, main_count_third_d;
  logic [1:0] prescaler_ratio_word_q, prescaler_ratio_word_d;
  logic [1:0] irq_status_q, irq_status_d;
  logic [1:0] irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  logic lock_out_q, lock_out_d;
  logic combined_lock_q, combined_lock_d;

  // ---------------------------------------------------------------
  // Input edge detection
  // ---------------------------------------------------------------
  logic ref_prev_q, aux_prev_q, main_in_prev_q;
  logic main_in;
  logic ref_edge, aux_edge, main_edge;

  assign main_in = test_input ^ rf_input;
  assign ref_edge = ref_input & ~ref_prev_q;
  assign aux_edge = aux_input & ~aux_prev_q;
  assign main_edge = main_in & ~main_in_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
      aux_prev_q <= 1'b0;
      // XOR idles high with the test pin parked, so no false edge after reset
      main_in_prev_q <= 1'b1;
    end else begin
      ref_prev_q <= ref_input;
      aux_prev_q <= aux_input;
      main_in_prev_q <= main_in;
    end
  end

  // ---------------------------------------------------------------
  // Division ratios
  // ---------------------------------------------------------------
  logic [RATIO_W-1:0] main_ratio;
  logic [RATIO_W-1:0] aux_ratio;
  logic [RATIO_W-1:0] ref_first_ratio;
  logic [3:0] ref_sub_ratio;

  always_comb begin
    main_ratio = RATIO_W'((RATIO_W'(main_count_first_q) + RATIO_W'(2)) * LDTM_MOD_LOW
      + RATIO_W'(main_count_second_q) * LDTM_MOD_MID);
    if (prescaler_ratio_word_q == LDTM_PR_THREE_MOD) begin
      main_ratio = RATIO_W'(main_ratio
        + (RATIO_W'(main_count_third_q) + RATIO_W'(1)) * LDTM_MOD_HIGH);
    end
    aux_ratio = aux_prescale_select_q ? RATIO_W'(aux_ratio_divider_q)
      : RATIO_W'(RATIO_W'(aux_ratio_divider_q) * LDTM_AUX_PRESC_DIV);
    ref_first_ratio = RATIO_W'(reference_ratio_divider_q);
    ref_sub_ratio = {1'b0, reference_sub_counter_q} + 4'h1;
  end

  // ---------------------------------------------------------------
  // Dividers
  // ---------------------------------------------------------------
  // Counters see only enables and ratios, never the test selection
  logic ref_first_tc, reference_divider_pulse;
  logic aux_divider_pulse, main_divider_pulse;

  ldtm_divider #(.W(RATIO_W)) u_ref_first (
    .pclk(pclk),
    .presetn(presetn),
    .enable(1'b1),
    .step(ref_edge),
    .ratio(ref_first_ratio),
    .tc_q(ref_first_tc)
  );

  ldtm_divider #(.W(4)) u_ref_sub (
    .pclk(pclk),
    .presetn(presetn),
    .enable(1'b1),
    .step(ref_first_tc),
    .ratio(ref_sub_ratio),
    .tc_q(reference_divider_pulse)
  );

  ldtm_divider #(.W(RATIO_W)) u_aux_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(aux_counter_enable_q),
    .step(aux_edge),
    .ratio(aux_ratio),
    .tc_q(aux_divider_pulse)
  );

  ldtm_divider #(.W(RATIO_W)) u_main_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(main_counter_enable_q),
    .step(main_edge),
    .ratio(main_ratio),
    .tc_q(main_divider_pulse)
  );

  // ---------------------------------------------------------------
  // Phase detectors
  // ---------------------------------------------------------------
  logic main_locked, aux_locked;

  ldtm_phase_lock u_main_pd (
    .pclk(pclk),
    .presetn(presetn),
    .ref_edge(ref_edge),
    .ref_pulse(reference_divider_pulse),
    .loop_pulse(main_divider_pulse),
    .locked_q(main_locked)
  );

  ldtm_phase_lock u_aux_pd (
    .pclk(pclk),
    .presetn(presetn),
    .ref_edge(ref_edge),
    .ref_pulse(reference_divider_pulse),
    .loop_pulse(aux_divider_pulse),
    .locked_q(aux_locked)
  );

  // ---------------------------------------------------------------
  // Lock output selection
  // ---------------------------------------------------------------
  ldtm_sel_type sel;

  always_comb begin
    sel = ldtm_sel_type'({test_select_high_q, test_select_low_q});
    combined_lock_d = (main_locked | ~main_counter_enable_q)
      & (aux_locked | ~aux_counter_enable_q);
    unique case (sel)
      LDTM_SEL_LOCK: lock_out_d = combined_lock_d;
      LDTM_SEL_REF: lock_out_d = reference_divider_pulse;
      LDTM_SEL_AUX: lock_out_d = ~aux_divider_pulse;
      LDTM_SEL_MAIN: lock_out_d = ~main_divider_pulse;
    endcase
  end

  // ---------------------------------------------------------------
  // Lock events and interrupt
  // ---------------------------------------------------------------
  logic gained_evt, lost_evt;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  assign gained_evt = combined_lock_d & ~combined_lock_q;
  assign lost_evt = ~combined_lock_d & combined_lock_q;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // One wait state so read data always leave a flop
  logic apb_access, apb_commit, apb_wr;
  logic addr_ok;

  assign apb_access = psel & penable;
  assign apb_commit = apb_access & pready_q;
  assign apb_wr = apb_commit & pwrite & ~pslverr_q;

  always_comb begin
    unique case (paddr)
      LDTM_ENABLE_OFS, LDTM_REF_OFS, LDTM_AUX_OFS, LDTM_MAIN_OFS,
      LDTM_STATUS_OFS, LDTM_IRQ_STATUS_OFS, LDTM_IRQ_MASK_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    main_counter_enable_d = main_counter_enable_q;
    aux_counter_enable_d = aux_counter_enable_q;
    test_select_low_d = test_select_low_q;
    test_select_high_d = test_select_high_q;
    reference_ratio_divider_d = reference_ratio_divider_q;
    reference_sub_counter_d = reference_sub_counter_q;
    aux_ratio_divider_d = aux_ratio_divider_q;
    aux_prescale_select_d = aux_prescale_select_q;
    main_count_first_d = main_count_first_q;
    main_count_second_d = main_count_second_q;
    main_count_third_d = main_count_third_q;
    prescaler_ratio_word_d = prescaler_ratio_word_q;
    irq_mask_d = irq_mask_q;
    irq_clr = 2'h0;
    if (apb_wr) begin
      unique case (paddr)
        LDTM_ENABLE_OFS: begin
          main_counter_enable_d = pwdata[LDTM_EN_MAIN_BIT];
          aux_counter_enable_d = pwdata[LDTM_EN_AUX_BIT];
          test_select_low_d = pwdata[LDTM_EN_TLOW_BIT];
          test_select_high_d = pwdata[LDTM_EN_THIGH_BIT];
        end
        LDTM_REF_OFS: begin
          reference_ratio_divider_d = pwdata[REF_W-1:0];
          reference_sub_counter_d = pwdata[LDTM_REF_SUB_LSB +: 3];
        end
        LDTM_AUX_OFS: begin
          aux_ratio_divider_d = pwdata[AUX_W-1:0];
          aux_prescale_select_d = pwdata[LDTM_AUX_PRESC_BIT];
        end
        LDTM_MAIN_OFS: begin
          main_count_first_d = pwdata[FIRST_W-1:0];
          main_count_second_d = pwdata[LDTM_MAIN_SECOND_LSB +: SECOND_W];
          main_count_third_d = pwdata[LDTM_MAIN_THIRD_LSB +: THIRD_W];
          prescaler_ratio_word_d = pwdata[LDTM_MAIN_PR_LSB +: 2];
        end
        LDTM_IRQ_STATUS_OFS: irq_clr = pwdata[1:0];
        LDTM_IRQ_MASK_OFS: irq_mask_d = pwdata[1:0];
        default: irq_clr = 2'h0;
      endcase
    end
    irq_set = 2'h0;
    irq_set[LDTM_IRQ_GAINED_BIT] = gained_evt;
    irq_set[LDTM_IRQ_LOST_BIT] = lost_evt;
    // Set wins over a same-cycle clear
    irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
    irq_d = |(irq_status_d & irq_mask_d);
  end

  always_comb begin
    pready_d = apb_access & ~pready_q;
    pslverr_d = apb_access & ~pready_q & ~addr_ok;
    prdata_d = prdata_q;
    if (apb_access && !pready_q) begin
      prdata_d = 32'h0;
      if (!pwrite) begin
        unique case (paddr)
          LDTM_ENABLE_OFS: prdata_d[3:0] = {test_select_high_q, test_select_low_q,
            aux_counter_enable_q, main_counter_enable_q};
          LDTM_REF_OFS: prdata_d[14:0] = {reference_sub_counter_q, reference_ratio_divider_q};
          LDTM_AUX_OFS: prdata_d[12:0] = {aux_prescale_select_q, aux_ratio_divider_q};
          LDTM_MAIN_OFS: prdata_d[25:0] = {prescaler_ratio_word_q, main_count_third_q,
            main_count_second_q, main_count_first_q};
          LDTM_STATUS_OFS: prdata_d[3:0] = {lock_out_q, aux_locked, main_locked,
            combined_lock_q};
          LDTM_IRQ_STATUS_OFS: prdata_d[1:0] = irq_status_q;
          LDTM_IRQ_MASK_OFS: prdata_d[1:0] = irq_mask_q;
          default: prdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {test_select_high_q, test_select_low_q, aux_counter_enable_q,
        main_counter_enable_q} <= LDTM_ENABLE_RST;
      reference_ratio_divider_q <= '0;
      reference_sub_counter_q <= '0;
      aux_ratio_divider_q <= '0;
      aux_prescale_select_q <= 1'b0;
      main_count_first_q <= '0;
      main_count_second_q <= '0;
      main_count_third_q <= '0;
      prescaler_ratio_word_q <= '0;
      irq_status_q <= LDTM_IRQ_RST;
      irq_mask_q <= LDTM_IRQ_RST;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      lock_out_q <= 1'b1;
      combined_lock_q <= 1'b1;
    end else begin
      main_counter_enable_q <= main_counter_enable_d;
      aux_counter_enable_q <= aux_counter_enable_d;
      test_select_low_q <= test_select_low_d;
      test_select_high_q <= test_select_high_d;
      reference_ratio_divider_q <= reference_ratio_divider_d;
      reference_sub_counter_q <= reference_sub_counter_d;
      aux_ratio_divider_q <= aux_ratio_divider_d;
      aux_prescale_select_q <= aux_prescale_select_d;
      main_count_first_q <= main_count_first_d;
      main_count_second_q <= main_count_second_d;
      main_count_third_q <= main_count_third_d;
      prescaler_ratio_word_q <= prescaler_ratio_word_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      lock_out_q <= lock_out_d;
      combined_lock_q <= combined_lock_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign lock_out = lock_out_q;

endmodule

/* dv/ldtm_assertions.sv */
`timescale 1ns/1ps
module ldtm_assertions import ldtm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ref_input,
  input wire logic aux_input,
  input wire logic rf_input,
  input wire logic test_input,
  input wire logic lock_out,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Enable word shadow and counted edge history
  // ------------------------------------------------------------
  logic [3:0] en_q, en_d, age_q, age_d, rh_q, rh_d, mh_q, mh_d;
  logic rp_q, rp_d, mp_q, mp_d, wr_en, steady;
  assign wr_en = psel && penable && pready && pwrite && (paddr == LDTM_ENABLE_OFS);
  assign steady = age_q > 4'h2;
  always_comb begin
    en_d = wr_en ? pwdata[3:0] : en_q;
    age_d = wr_en ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
    rp_d = ref_input;
    mp_d = rf_input ^ test_input;
    // Four deep, so a pipeline one stage longer still matches
    rh_d = {rh_q[2:0], ref_input && !rp_q};
    mh_d = {mh_q[2:0], mp_d && !mp_q};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Main input XOR idles high
      {en_q, age_q, rh_q, mh_q, rp_q, mp_q} <= 18'h1;
    end else begin
      {en_q, age_q, rh_q, mh_q, rp_q, mp_q} <= {en_d, age_d, rh_d, mh_d, rp_d, mp_d};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_APB_WAIT: assert property (psel && $rose(penable) |=> pready)
    else $error("pready late");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready && (paddr > LDTM_IRQ_MASK_OFS || paddr[1:0] != 2'h0))
    else $error("pslverr on mapped address");
  AST_LOCK_IDLE: assert property (en_q == 4'h0 && steady |-> lock_out)
    else $error("lock low with both loops disabled");
  AST_SWITCH: assert property (wr_en && pwdata[3:0] == 4'h0 |-> ##[2:3] lock_out)
    else $error("lock source not switched");
  AST_REF_PULSE: assert property (en_q[3:2] == 2'h1 && steady && lock_out |=> !lock_out || !steady)
    else $error("ref pulse too long");
  AST_REF_CAUSE: assert property (en_q[3:2] == 2'h1 && steady && $rose(lock_out) |-> rh_q != 4'h0)
    else $error("ref pulse without ref edge");
  AST_AUX_PULSE: assert property (en_q[3:2] == 2'h2 && steady && !lock_out |=> lock_out || !steady)
    else $error("aux pulse too long");
  AST_MAIN_PULSE: assert property (en_q[3:2] == 2'h3 && steady && !lock_out |=> lock_out || !steady)
    else $error("main pulse too long");
  AST_MAIN_CAUSE: assert property (en_q[3:2] == 2'h3 && steady && $fell(lock_out) |-> mh_q != 4'h0)
    else $error("main pulse without main edge");
endmodule

bind ldtm_lock_detect_test_mux ldtm_assertions u_ast (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_input(ref_input),
  .aux_input(aux_input), .rf_input(rf_input), .test_input(test_input),
  .lock_out(lock_out), .irq(irq));

/* dv/ldtm_pin_host.sv */
`timescale 1ns/1ps
module ldtm_pin_host (
  input wire logic pclk,
  output logic ref_input,
  output logic aux_input,
  output logic rf_input,
  output logic test_input
);
  // Test pin parked high; only a masked pulse dips it
  initial begin
    ref_input = 1'b0;
    aux_input = 1'b0;
    rf_input = 1'b0;
    test_input = 1'b1;
  end
  // One counted edge per selected line, low sample between edges
  task automatic pulse(input logic [3:0] m);
    @(posedge pclk);
    ref_input <= m[0];
    aux_input <= m[1];
    rf_input <= m[2];
    test_input <= !m[3];
    @(posedge pclk);
    ref_input <= 1'b0;
    aux_input <= 1'b0;
    rf_input <= 1'b0;
    test_input <= 1'b1;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import ldtm_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic [31:0] rnd = 32'h00017846;
  logic pready, pslverr, ref_input, aux_input, rf_input, test_input, lock_out, irq, e;
  int bad_count, cmp_count, ecount, tmode, nr, sm, na, f, s, t;
  int q[$];

  always #10 pclk = ~pclk;

  ldtm_lock_detect_test_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_input(ref_input), .aux_input(aux_input),
    .rf_input(rf_input), .test_input(test_input), .lock_out(lock_out), .irq(irq));
  ldtm_pin_host u_host (.pclk(pclk), .ref_input(ref_input), .aux_input(aux_input),
    .rf_input(rf_input), .test_input(test_input));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function int next();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return int'(rnd[7:0]);
  endfunction

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                     input string n);
    apb(1'b0, a, 32'h0);
    chk(n, x, r & m);
  endtask

  task automatic run(input int n, input logic [3:0] m);
    repeat (n) begin
      ecount++;
      u_host.pulse(m);
    end
  endtask

  task automatic settle(input logic [3:0] en, input int mode);
    tmode = 0;
    apb(1'b1, LDTM_ENABLE_OFS, {28'h0, en});
    repeat (4) @(posedge pclk);
    tmode = mode;
  endtask

  // Pulse positions in counted edges; negedge keeps clear of the driver
  always @(negedge pclk) begin
    if (tmode != 0 && lock_out !== (tmode != 1)) q.push_back(ecount);
  end

  task automatic measure(input int mode, input int ratio, input logic [3:0] m,
                         input logic [3:0] en, input string n);
    settle(en, mode);
    q.delete();
    run(ratio * 2 + 2, m);
    if (mode == 1) begin
      // Detour through lock mode while edges keep coming
      settle(4'h0, 0);
      run(ratio / 2 + 1, m);
      settle(en, mode);
    end
    run(ratio * 2 + 2, m);
    tmode = 0;
    chk(n, 32'h1, {31'h0, q.size() > 2});
    if (q.size() > 1) chk(n, ratio, q[1] - q[0]);
    foreach (q[i]) chk(n, 32'h0, (q[i] - q[0]) % ratio);
  endtask

  task automatic periods(input int n);
    repeat (n) for (int j = 0; j < 128; j++) u_host.pulse(j == 64 ? 4'h5 : 4'h4);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("lock_out reset", 32'h1, {31'h0, lock_out});
    rdc(LDTM_ENABLE_OFS, 32'hf, 32'h0, "enable reset");
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    for (int i = 0; i < 2; i++) begin
      nr = (i == 1) ? 0 : next() % 8 + 1;
      sm = (i == 1) ? 7 : next() % 8;
      apb(1'b1, LDTM_REF_OFS, 32'(nr) | (32'(sm) << LDTM_REF_SUB_LSB));
      measure(1, (nr == 0 ? 1 : nr) * (sm + 1), 4'h1, 4'h4, "ref ratio");
    end
    for (int pa = 0; pa < 2; pa++) begin
      na = next() % 8 + 1;
      apb(1'b1, LDTM_AUX_OFS, 32'(na) | (32'(pa) << LDTM_AUX_PRESC_BIT));
      measure(2, pa == 1 ? na : na * 4, 4'h2, 4'ha, "aux ratio");
    end
    for (int p = 1; p < 3; p++) begin
      f = next() % 2;
      s = next() % 4;
      t = next() % 2;
      apb(1'b1, LDTM_MAIN_OFS, 32'(f) | (32'(s) << LDTM_MAIN_SECOND_LSB) |
          (32'(t) << LDTM_MAIN_THIRD_LSB) | (32'(p) << LDTM_MAIN_PR_LSB));
      measure(3, (f + 2) * 64 + s * 65 + (p == 2 ? (t + 1) * 72 : 0),
              p == 1 ? 4'h8 : 4'h4, 4'hd, "main ratio");
    end
    apb(1'b1, LDTM_REF_OFS, 32'h1);
    // Unused prescaler code falls back to two-modulus
    apb(1'b1, LDTM_MAIN_OFS, 32'h03000000);
    settle(4'h0, 0);
    settle(4'h1, 0);
    periods(4);
    rdc(LDTM_STATUS_OFS, 32'h9, 32'h9, "locked");
    apb(1'b1, LDTM_IRQ_MASK_OFS, 32'h0);
    apb(1'b1, LDTM_IRQ_STATUS_OFS, 32'h3);
    rdc(LDTM_IRQ_STATUS_OFS, 32'h3, 32'h0, "irq status clear");
    settle(4'h3, 0);
    periods(2);
    rdc(LDTM_STATUS_OFS, 32'h9, 32'h0, "aux unlocked");
    rdc(LDTM_IRQ_STATUS_OFS, 32'h3, 32'h2, "lost event");
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, LDTM_IRQ_MASK_OFS, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, LDTM_IRQ_STATUS_OFS, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    settle(4'h1, 0);
    periods(1);
    chk("relock", 32'h1, {31'h0, lock_out});
    rdc(LDTM_IRQ_STATUS_OFS, 32'h3, 32'h1, "gained event");
    chk("irq still masked", 32'h0, {31'h0, irq});
    test_done();
  end
endmodule
